/* File: include/rps_pkg.sv */
// Package with register map, field layout, reset values and bus slave states for the output pin select block.
package rps_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int          NUM_REGS      = 6;
   localparam int          NUM_PINS      = 12;
   localparam int          FIRST_PIN     = 4;
   localparam int          SEL_W         = 5;
   localparam int          REG_W         = 16;
   localparam int          ADDR_W        = 12;
   localparam int          IDX_W         = 3;
   localparam logic [11:0] OFS_PINS_4_5   = 12'h000;
   localparam logic [11:0] OFS_PINS_6_7   = 12'h004;
   localparam logic [11:0] OFS_PINS_8_9   = 12'h008;
   localparam logic [11:0] OFS_PINS_10_11 = 12'h00C;
   localparam logic [11:0] OFS_PINS_12_13 = 12'h010;
   localparam logic [11:0] OFS_PINS_14_15 = 12'h014;
   localparam logic [11:0] OFS_STATUS     = 12'h018;

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int          LO_SEL_LSB    = 0;
   localparam int          HI_SEL_LSB    = 8;
   localparam logic [15:0] IMPL_MASK     = 16'h1F1F;
   localparam logic [15:0] SEL_RESET     = 16'h0000;
   localparam logic [4:0]  SEL_NONE      = 5'h00;
   localparam logic [4:0]  NUM_FUNCS_DEF = 5'h12;
   localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Bus slave states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      RPS_IDLE   = 2'b01,
      RPS_ACCESS = 2'b10
   } rps_state_t;

endpackage : rps_pkg

/* File: design/rps_sel_mem.sv */
// Selector register store: six 16-bit words with registered read data.
`timescale 1ns/1ns
`default_nettype none
module rps_sel_mem
   import rps_pkg::*;
#(
   parameter int DEPTH = NUM_REGS
)
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   // Write port
   input  wire logic                 we_i,
   input  wire logic [IDX_W-1:0]     widx_i,
   input  wire logic [REG_W-1:0]     wdata_i,
   // Read port
   input  wire logic [IDX_W-1:0]     ridx_i,
   output logic      [REG_W-1:0]     rdata_o,
   // Whole contents for the pin decoders
   output logic      [DEPTH*REG_W-1:0] flat_o
);

   initial
   begin
      if (DEPTH < 1 || DEPTH > (1 << IDX_W))
         $error("rps_sel_mem: DEPTH out of range");
   end

   logic [REG_W-1:0] mem_reg [DEPTH];

   // Unimplemented bits are masked on write, so they can never hold a one.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= SEL_RESET;
         rdata_o <= SEL_RESET;
      end
      else
      begin
         if (we_i && (int'(widx_i) < DEPTH))
            mem_reg[widx_i] <= wdata_i & IMPL_MASK;
         rdata_o <= (int'(ridx_i) < DEPTH) ? mem_reg[ridx_i] : SEL_RESET;
      end
   end

   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         flat_o[i*REG_W +: REG_W] = mem_reg[i];
   end

endmodule : rps_sel_mem
`default_nettype wire

/* File: design/rps_pin_drv.sv */
// One remappable pin: picks the peripheral output named by its selector code.
`timescale 1ns/1ns
`default_nettype none
module rps_pin_drv
   import rps_pkg::*;
#(
   parameter int NFUNC = 18
)
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // Selector and peripheral outputs
   input  wire logic [SEL_W-1:0] sel_i,
   input  wire logic [NFUNC:0]   func_out_i,
   input  wire logic [NFUNC:0]   func_oe_i,
   // Pin drive
   output logic                  pin_o,
   output logic                  pin_oe_o,
   output logic                  periph_own_o
);

   initial
   begin
      if (NFUNC < 1 || NFUNC > 31)
         $error("rps_pin_drv: NFUNC out of range");
   end

   // Code zero or an unknown code hands the pin back to port logic.
   wire valid_sel = (sel_i != SEL_NONE) && (int'(sel_i) <= NFUNC);

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pin_o        <= 1'b0;
         pin_oe_o     <= 1'b0;
         periph_own_o <= 1'b0;
      end
      else
      begin
         pin_o        <= valid_sel & func_out_i[sel_i];
         pin_oe_o     <= valid_sel & func_oe_i[sel_i];
         periph_own_o <= valid_sel;
      end
   end

   a_own_tracks_sel : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sel_i == SEL_NONE) |=> !periph_own_o && !pin_oe_o)
      else $error("pin kept a peripheral driver with selector zero");

endmodule : rps_pin_drv
`default_nettype wire

/* File: design/rps_out_sel.sv */
// APB-reached output pin select block for remappable pins 4 to 15.
//
// Function
// - The word at offset 0x000 routes the code in bits 12-8 to pin 5 and bits 4-0 to pin 4.
// - The word at offset 0x004 routes bits 12-8 to pin 7 and bits 4-0 to pin 6.
// - The word at offset 0x008 routes bits 12-8 to pin 9 and bits 4-0 to pin 8.
// - The word at offset 0x00C routes bits 12-8 to pin 11 and bits 4-0 to pin 10.
// - The word at offset 0x010 routes bits 12-8 to pin 13 and bits 4-0 to pin 12.
// - The word at offset 0x014 routes bits 12-8 to pin 15 and bits 4-0 to pin 14.
// - Bits 15-13 and 7-5 of every select word ignore writes and read as zero.
// - Every 5-bit selector is read/write and clears to zero at reset.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rps_out_sel
   import rps_pkg::*;
#(
   parameter int NFUNC = int'(NUM_FUNCS_DEF)
)
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rstn_i,
   // APB slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [ADDR_W-1:0]     paddr_i,
   input  wire logic [31:0]           pwdata_i,
   input  wire logic [3:0]            pstrb_i,
   output logic                       pready_o,
   output logic      [31:0]           prdata_o,
   output logic                       pslverr_o,
   // Peripheral output functions, index 0 unused
   input  wire logic [NFUNC:0]        func_out_i,
   input  wire logic [NFUNC:0]        func_oe_i,
   // Remappable pins 4 to 15, bit 0 is pin 4
   output logic      [NUM_PINS-1:0]   pin_o,
   output logic      [NUM_PINS-1:0]   pin_oe_o,
   output logic      [NUM_PINS-1:0]   periph_own_o
);

   initial
   begin
      if (NFUNC < 1 || NFUNC > 31)
         $error("rps_out_sel: NFUNC out of range");
   end

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   function automatic logic addr_is_sel(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'h0) && (a <= OFS_PINS_14_15);
   endfunction : addr_is_sel

   function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
      return a[IDX_W+1:2];
   endfunction : addr_idx

   rps_state_t state_reg;
   rps_state_t state_next;

   wire                  setup_ok  = psel_i && !penable_i;
   wire                  hit_sel   = addr_is_sel(paddr_i);
   wire                  hit_stat  = (paddr_i == OFS_STATUS);
   wire                  hit_any   = hit_sel || hit_stat;
   wire [IDX_W-1:0]      idx       = addr_idx(paddr_i);
   // Writes land in the setup cycle; the access cycle then answers at once.
   wire                  do_write  = setup_ok && pwrite_i && hit_sel && (state_reg == RPS_IDLE);
   wire [REG_W-1:0]      mem_rdata;
   wire [REG_W-1:0]      cur_word;
   wire [REG_W-1:0]      wr_word;
   wire [NUM_REGS*REG_W-1:0] sel_flat;
   wire [NUM_PINS-1:0]   own_w;

   // Byte lanes: only the two low lanes carry select bits.
   assign wr_word = {pstrb_i[1] ? pwdata_i[15:8] : cur_word[15:8],
                     pstrb_i[0] ? pwdata_i[7:0]  : cur_word[7:0]};
   assign cur_word = sel_flat[int'(idx)*REG_W +: REG_W];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         RPS_IDLE:   state_next = setup_ok ? RPS_ACCESS : RPS_IDLE;
         RPS_ACCESS: state_next = RPS_IDLE;
         default:    state_next = RPS_IDLE;
      endcase
   end

   // -----------------------------------------------------------------
   // Selector store
   // -----------------------------------------------------------------
   rps_sel_mem #(
      .DEPTH (NUM_REGS)
   ) u_mem (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .we_i    (do_write),
      .widx_i  (idx),
      .wdata_i (wr_word),
      .ridx_i  (idx),
      .rdata_o (mem_rdata),
      .flat_o  (sel_flat)
   );

   // -----------------------------------------------------------------
   // Pin routing: even pin from bits 4-0, odd pin from bits 12-8
   // -----------------------------------------------------------------
   // Register r feeds pins 2r+4 and 2r+5.
   for (genvar p = 0; p < NUM_PINS; p++)
   begin : g_pin
      localparam int REG_IX = p / 2;
      localparam int LSB    = (p % 2 == 0) ? LO_SEL_LSB : HI_SEL_LSB;
      rps_pin_drv #(
         .NFUNC (NFUNC)
      ) u_drv (
         .clk_i        (clk_i),
         .rstn_i       (rstn_i),
         .sel_i        (sel_flat[REG_IX*REG_W+LSB +: SEL_W]),
         .func_out_i   (func_out_i),
         .func_oe_i    (func_oe_i),
         .pin_o        (pin_o[p]),
         .pin_oe_o     (pin_oe_o[p]),
         .periph_own_o (own_w[p])
      );
   end

   assign periph_own_o = own_w;

   // -----------------------------------------------------------------
   // Bus answer
   // -----------------------------------------------------------------
   // Read data are picked in the setup cycle and registered, so the
   // answer is always one access cycle, zero wait states.
   wire [31:0] rd_word = hit_stat ? {{(32-NUM_PINS){1'b0}}, own_w}
                                  : {{(32-REG_W){1'b0}}, cur_word};

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_reg <= RPS_IDLE;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         pready_o  <= setup_ok;
         pslverr_o <= setup_ok && !(hit_any && !(pwrite_i && hit_stat));
      end
   end

   // Read data leave from a flip-flop; refused reads return zero.
   logic rd_pending_reg;
   logic rd_err_reg;
   logic rd_stat_q;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rd_pending_reg <= 1'b0;
         rd_err_reg     <= 1'b0;
         rd_stat_q      <= 1'b0;
         prdata_o       <= RDATA_RESET;
      end
      else
      begin
         rd_pending_reg <= setup_ok && !pwrite_i;
         rd_err_reg     <= setup_ok && !hit_any;
         rd_stat_q      <= setup_ok && hit_stat;
         prdata_o       <= (setup_ok && !pwrite_i && hit_any) ? rd_word : RDATA_RESET;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_sel_write;
      psel_i && !penable_i && pwrite_i && (paddr_i == OFS_PINS_4_5) && pstrb_i[0];
   endsequence

   a_pin4_route : assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_sel_write ##1 1'b1 |-> (sel_flat[SEL_W-1:0] == $past(pwdata_i[4:0])))
      else $error("pin 4 selector did not take written code");

   a_pin5_route : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (psel_i && !penable_i && pwrite_i && (paddr_i == OFS_PINS_4_5) && pstrb_i[1])
      |=> (sel_flat[HI_SEL_LSB +: SEL_W] == $past(pwdata_i[12:8])))
      else $error("pin 5 selector did not take written code");

   a_pin7_route : assert property (@(posedge clk_i) disable iff (!rstn_i)
      $changed(sel_flat[REG_W+HI_SEL_LSB +: SEL_W]) |-> $past(do_write && idx == 3'h1))
      else $error("pin 7 selector changed without a write");

   a_pin9_drive : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sel_flat[2*REG_W+HI_SEL_LSB +: SEL_W] == 5'h01) ##1
      (sel_flat[2*REG_W+HI_SEL_LSB +: SEL_W] == 5'h01) |-> pin_o[5] == $past(func_out_i[1]))
      else $error("pin 9 not driven by function 1");

   a_pin10_own : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sel_flat[3*REG_W +: SEL_W] != SEL_NONE) && (int'(sel_flat[3*REG_W +: SEL_W]) <= NFUNC)
      |=> own_w[6])
      else $error("pin 10 not owned by peripheral");

   a_pin13_oe : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sel_flat[4*REG_W+HI_SEL_LSB +: SEL_W] == 5'h02) ##1
      (sel_flat[4*REG_W+HI_SEL_LSB +: SEL_W] == 5'h02) |-> pin_oe_o[9] == $past(func_oe_i[2]))
      else $error("pin 13 enable not from function 2");

   a_pin14_free : assert property (@(posedge clk_i) disable iff (!rstn_i)
      (sel_flat[5*REG_W +: SEL_W] == SEL_NONE) |=> !pin_oe_o[10])
      else $error("pin 14 driven with selector zero");

   a_unimpl_zero : assert property (@(posedge clk_i) disable iff (!rstn_i)
      pready_o && rd_pending_reg |-> (prdata_o & ~{16'h0000, IMPL_MASK}) == 32'h0000_0000
                                     || rd_stat_q)
      else $error("unimplemented bits read as one");

   a_store_read : assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_pending_reg && !rd_err_reg && !rd_stat_q |-> prdata_o == {16'h0000, mem_rdata})
      else $error("read data differ from the store read port");

   a_reset_clear : assert property (@(posedge clk_i)
      $rose(rstn_i) |-> (sel_flat == '0))
      else $error("selectors not cleared by reset");

endmodule : rps_out_sel
`default_nettype wire

/* File: verif/rps_out_sel_tb_top.sv */
// Self-checking testbench for the output pin select block.
`timescale 1ns/1ns
`default_nettype none
module rps_out_sel_tb_top
   import rps_pkg::*;
();
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int NF = 18;
   logic              clk_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic              psel_i = 1'b0;
   logic              penable_i = 1'b0;
   logic              pwrite_i = 1'b0;
   logic [11:0]       paddr_i = 12'h000;
   logic [31:0]       pwdata_i = 32'h0000_0000;
   logic [3:0]        pstrb_i = 4'hF;
   logic [NF:0]       func_out_i = '0;
   logic [NF:0]       func_oe_i = '0;
   logic              pready_o;
   logic              pslverr_o;
   logic [31:0]       prdata_o;
   logic [11:0]       pin_o;
   logic [11:0]       pin_oe_o;
   logic [11:0]       periph_own_o;
   logic [15:0]       model [6];
   logic [11:0]       ofs [6];
   int                error_cnt = 0;
   int                comparisons = 0;

   always #4 clk_i = ~clk_i;

   rps_out_sel #(.NFUNC(NF)) rps_out_sel_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .func_out_i(func_out_i), .func_oe_i(func_oe_i), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .periph_own_o(periph_own_o));

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // A code owns the pin only when it names an implemented function.
   function automatic logic [11:0] own_bits();
      logic [11:0] b;
      logic [4:0]  s;
      for (int k = 0; k < 12; k++)
      begin
         s = 5'(model[k/2] >> ((k%2)*8));
         b[k] = (s != 5'h00) && (int'(s) <= NF);
      end
      return b;
   endfunction : own_bits

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      pstrb_i   <= s;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 16);
      chk("pready", 32'(pready_o), 32'h1);
      r = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, ofs[i], d, s, r, e);
      chk("wr_err", 32'(e), 32'h0);
      if (s[0])
         model[i][7:0] = d[7:0] & IMPL_MASK[7:0];
      if (s[1])
         model[i][15:8] = d[15:8] & IMPL_MASK[15:8];
   endtask : wr

   task automatic rd(input int i);
      logic [31:0] r;
      logic        e;
      apb(1'b0, ofs[i], 32'h0, 4'h0, r, e);
      chk("rd_data", r, 32'(model[i]));
      chk("rd_err", 32'(e), 32'h0);
   endtask : rd

   task automatic chk_pins;
      logic [11:0] own;
      logic [4:0]  s;
      own = own_bits();
      @(posedge clk_i);
      func_out_i <= (NF+1)'($urandom);
      func_oe_i  <= (NF+1)'($urandom);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      for (int k = 0; k < 12; k++)
      begin
         s = 5'(model[k/2] >> ((k%2)*8));
         chk("own", 32'(periph_own_o[k]), 32'(own[k]));
         if (own[k])
         begin
            chk("pin", 32'(pin_o[k]), 32'(func_out_i[s]));
            chk("pin_oe", 32'(pin_oe_o[k]), 32'(func_oe_i[s]));
         end
         else
            chk("pin_oe_off", 32'(pin_oe_o[k]), 32'h0);
      end
   endtask : chk_pins

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      logic        e;
      void'($urandom(32'h8707B925));
      ofs = '{OFS_PINS_4_5, OFS_PINS_6_7, OFS_PINS_8_9,
              OFS_PINS_10_11, OFS_PINS_12_13, OFS_PINS_14_15};
      foreach (model[i]) model[i] = SEL_RESET;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 6; i++) rd(i);
      chk_pins();
      $display("test reset values done");
      for (int n = 0; n < 24; n++)
      begin
         wr(int'($urandom % 6), $urandom, 4'hF);
         rd(n % 6);
      end
      chk_pins();
      $display("test random writes done");
      // Every code once, so both ends of the implemented range are hit.
      for (int c = 0; c < 32; c++)
      begin
         wr(c % 6, 32'(c) | (32'(31 - c) << 8), 4'hF);
         chk_pins();
      end
      $display("test code sweep done");
      wr(2, 32'hFFFF_FFFF, 4'h1);
      rd(2);
      wr(3, 32'hFFFF_FFFF, 4'h2);
      rd(3);
      $display("test byte strobes done");
      apb(1'b0, 12'h01C, 32'h0, 4'h0, r, e);
      chk("unmapped_err", 32'(e), 32'h1);
      chk("unmapped_data", r, 32'h0);
      apb(1'b0, 12'h006, 32'h0, 4'h0, r, e);
      chk("misaligned_err", 32'(e), 32'h1);
      apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, 4'hF, r, e);
      chk("unmapped_wr_err", 32'(e), 32'h1);
      apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF, 4'hF, r, e);
      chk("status_wr_err", 32'(e), 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0, 4'h0, r, e);
      chk("status", r, 32'(own_bits()));
      for (int i = 0; i < 6; i++) rd(i);
      $display("test refused accesses done");
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      foreach (model[i]) model[i] = SEL_RESET;
      for (int i = 0; i < 6; i++) rd(i);
      chk_pins();
      $display("test mid-run reset done");
      conclude();
   end

   // The whole sequence takes fewer than 500 cycles; this leaves ample margin.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      conclude();
   end

endmodule : rps_out_sel_tb_top
`default_nettype wire
